// ===== core/pin_level_pkg.sv
package pin_level_pkg;

  localparam int PORT_COUNT = 13;
  localparam int PORT_WIDTH = 8;
  localparam int ADDR_WIDTH = 20;
  localparam int SYNC_DEPTH = 3;

  localparam int NMI_PORT_INDEX = 3;
  localparam int NMI_BIT_INDEX  = 5;

  typedef logic [PORT_WIDTH-1:0] port_byte_t;
  typedef logic [ADDR_WIDTH-1:0] reg_addr_t;

  // byte offsets: ports 0..5, a..e, h, j
  localparam reg_addr_t PORT0_PIN_LEVELS = 20'h8c040;
  localparam reg_addr_t PORT1_PIN_LEVELS = 20'h8c041;
  localparam reg_addr_t PORT2_PIN_LEVELS = 20'h8c042;
  localparam reg_addr_t PORT3_PIN_LEVELS = 20'h8c043;
  localparam reg_addr_t PORT4_PIN_LEVELS = 20'h8c044;
  localparam reg_addr_t PORT5_PIN_LEVELS = 20'h8c045;
  localparam reg_addr_t PORTA_PIN_LEVELS = 20'h8c044;
  localparam reg_addr_t PORTB_PIN_LEVELS = 20'h8c04b;
  localparam reg_addr_t PORTC_PIN_LEVELS = 20'h8c04c;
  localparam reg_addr_t PORTD_PIN_LEVELS = 20'h8c04d;
  localparam reg_addr_t PORTE_PIN_LEVELS = 20'h8c04e;
  localparam reg_addr_t PORTH_PIN_LEVELS = 20'h8c051;
  localparam reg_addr_t PORTJ_PIN_LEVELS = 20'h8c052;

  localparam reg_addr_t PORT_OFFSET [PORT_COUNT] = '{
    PORT0_PIN_LEVELS, PORT1_PIN_LEVELS, PORT2_PIN_LEVELS, PORT3_PIN_LEVELS,
    PORT4_PIN_LEVELS, PORT5_PIN_LEVELS, PORTA_PIN_LEVELS, PORTB_PIN_LEVELS,
    PORTC_PIN_LEVELS, PORTD_PIN_LEVELS, PORTE_PIN_LEVELS, PORTH_PIN_LEVELS,
    PORTJ_PIN_LEVELS
  };

  // which pins physically exist per port; default all present
  localparam port_byte_t PIN_PRESENT_DEFAULT = 8'hff;
  localparam port_byte_t RESERVED_READ_VALUE = 8'h00;
  localparam port_byte_t UNMAPPED_READ_VALUE = 8'h00;
  localparam port_byte_t BYTE_ZERO           = 8'h00;

  typedef struct packed {
    reg_addr_t addr;
    port_byte_t wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    port_byte_t [PORT_COUNT-1:0] stage1;
    port_byte_t [PORT_COUNT-1:0] stage2;
    port_byte_t [PORT_COUNT-1:0] stage3;
    port_byte_t [PORT_COUNT-1:0] level;
    port_byte_t                  rdata;
  } pin_state_t;

endpackage

// ===== core/port_pin_input_readback.sv
// Function
// RULE1: eight-bit read-only register shows each pin level
// RULE2: readback ignores direction and function settings
// RULE3: nmi pin level appears in port3 bit5
// RULE4: absent pins reserved, writes change nothing
// RULE5: ports 0-5, a-e, h, j each register; port a shares port 4's offset, so it reads back port 4
// RULE6: pin levels synchronised before reaching read path
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module port_pin_input_readback #(
  parameter pin_level_pkg::port_byte_t PIN_PRESENT [pin_level_pkg::PORT_COUNT] =
    '{default: pin_level_pkg::PIN_PRESENT_DEFAULT}
) (
  // clock and reset
  input  wire logic                                          core_clk,
  input  wire logic                                          rst,
  // pins, async to core_clk
  input  wire pin_level_pkg::port_byte_t [pin_level_pkg::PORT_COUNT-1:0] pin_level_bit,
  input  wire logic                                          nmi_pin,
  // register port
  input  wire pin_level_pkg::reg_req_t                       req,
  output var  pin_level_pkg::port_byte_t                     rdata
);
  import pin_level_pkg::*;


  ////////////////////////////////////////////////////////////////////////////

  // the whole block state; one copy registered, one copy computed
  pin_state_t state;
  pin_state_t next_state;

  // pin bytes after the nmi merge, one per port
  port_byte_t raw [PORT_COUNT];

  ////////////////////////////////////////////////////////////////////////////

  // slot of each register in the pin and offset arrays
  localparam int SLOT_PORT0 = 0;
  localparam int SLOT_PORT1 = 1;
  localparam int SLOT_PORT2 = 2;
  localparam int SLOT_PORT3 = 3;
  localparam int SLOT_PORT4 = 4;
  localparam int SLOT_PORT5 = 5;
  localparam int SLOT_PORTA = 6;
  localparam int SLOT_PORTB = 7;
  localparam int SLOT_PORTC = 8;
  localparam int SLOT_PORTD = 9;
  localparam int SLOT_PORTE = 10;
  localparam int SLOT_PORTH = 11;
  localparam int SLOT_PORTJ = 12;
  localparam int SLOT_NONE  = -1;

  ////////////////////////////////////////////////////////////////////////////

  // port a shares port 4's offset; port 4 wins, so port a is unreachable
  function automatic int find_port(
    input reg_addr_t a
  );
    int hit;
    hit = SLOT_NONE;
    case (a)

      PORT0_PIN_LEVELS: begin
        hit = SLOT_PORT0;
      end

      PORT1_PIN_LEVELS: begin
        hit = SLOT_PORT1;
      end

      PORT2_PIN_LEVELS: begin
        hit = SLOT_PORT2;
      end

      PORT3_PIN_LEVELS: begin
        hit = SLOT_PORT3;
      end

      PORT4_PIN_LEVELS: begin
        hit = SLOT_PORT4;
      end

      PORT5_PIN_LEVELS: begin
        hit = SLOT_PORT5;
      end

      PORTB_PIN_LEVELS: begin
        hit = SLOT_PORTB;
      end

      PORTC_PIN_LEVELS: begin
        hit = SLOT_PORTC;
      end

      PORTD_PIN_LEVELS: begin
        hit = SLOT_PORTD;
      end

      PORTE_PIN_LEVELS: begin
        hit = SLOT_PORTE;
      end

      PORTH_PIN_LEVELS: begin
        hit = SLOT_PORTH;
      end

      PORTJ_PIN_LEVELS: begin
        hit = SLOT_PORTJ;
      end

      default: begin
        hit = SLOT_NONE;
      end

    endcase
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  // a level bit moves only once the second and third stages agree
  function automatic port_byte_t settle(
    input port_byte_t mid,
    input port_byte_t last,
    input port_byte_t held
  );
    port_byte_t r;
    r = held;
    for (int b = 0; b < PORT_WIDTH; b++) begin
      if (mid[b] == last[b]) begin
        r[b] = last[b];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  // absent pins read a fixed value rather than a floating input
  function automatic port_byte_t shape_read(
    input port_byte_t level,
    input port_byte_t present
  );
    port_byte_t r;
    r = (level & present) | (RESERVED_READ_VALUE & ~present);
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  // true when a decoded slot is a real register
  function automatic logic slot_valid(
    input int idx
  );
    logic v;
    v = 1'b0;
    if (idx >= 0) begin
      v = (idx < PORT_COUNT);
    end
    return v;
  endfunction

  // nmi level replaces port3 bit5 before synchronising
  genvar g;
  generate
    for (g = 0; g < PORT_COUNT; g++) begin : g_raw
      if (g == NMI_PORT_INDEX) begin : g_nmi
        always_comb begin
          raw[g] = pin_level_bit[g];
          raw[g][NMI_BIT_INDEX] = nmi_pin; // RULE3
        end
      end else begin : g_plain
        always_comb begin
          raw[g] = pin_level_bit[g]; // RULE2
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    int idx;
    idx = -1;
    next_state = state;

    // three synchroniser flops and a level flop per pin; the first may go metastable, so only later ones decide
    for (int i = 0; i < PORT_COUNT; i++) begin

      next_state.stage1[i] = raw[i]; // RULE6

      next_state.stage2[i] = state.stage1[i];

      next_state.stage3[i] = state.stage2[i];

      next_state.level[i] = settle(state.stage2[i], state.stage3[i], state.level[i]); // RULE6

    end

    // read data only in the cycle after the strobe; writes are ignored
    next_state.rdata = BYTE_ZERO; // RULE4

    if (req.rd) begin

      idx = find_port(req.addr);

      if (slot_valid(idx)) begin

        // reserved bits are undefined to software; a fixed value keeps reads repeatable
        next_state.rdata = shape_read(state.level[idx], PIN_PRESENT[idx]); // RULE1 RULE4 RULE5

      end else begin

        next_state.rdata = UNMAPPED_READ_VALUE;

      end

    end

  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end


  ////////////////////////////////////////////////////////////////////////////

  // output straight from the register; zero whenever no read was taken
  assign rdata = state.rdata;

  ////////////////////////////////////////////////////////////////////////////

endmodule

`default_nettype wire

// ===== sim/pin_level_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pin_level_monitor (
  input wire logic                                                  core_clk,
  input wire logic                                                  rst,
  input wire pin_level_pkg::port_byte_t [pin_level_pkg::PORT_COUNT-1:0] pin_level_bit,
  input wire logic                                                  nmi_pin,
  input wire pin_level_pkg::reg_req_t                               req,
  input wire pin_level_pkg::port_byte_t                             rdata
);
  import pin_level_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // eight quiet cycles outlast the synchroniser after reset
  sequence calm;
    ($stable(pin_level_bit) && $stable(nmi_pin))[*8];
  endsequence
  a_rdata_idle: assert property (!req.rd |=> rdata == 8'h00)
    else $error("rdata not zero without a read");
  a_port0_level: assert property (calm ##0 (req.rd && req.addr == PORT0_PIN_LEVELS)
    |=> rdata == $past(pin_level_bit[0])) else $error("port0 level wrong");
  a_nmi_bit: assert property (calm ##0 (req.rd && req.addr == PORT3_PIN_LEVELS)
    |=> rdata[5] == $past(nmi_pin)) else $error("nmi bit wrong");
  a_write_ignored: assert property (req.wr && !req.rd |=> rdata == 8'h00)
    else $error("write changed rdata");
  a_portj_level: assert property (calm ##0 (req.rd && req.addr == PORTJ_PIN_LEVELS)
    |=> rdata == $past(pin_level_bit[12])) else $error("portj level wrong");
  a_sync_delay: assert property (calm ##1 $changed(pin_level_bit[1]) ##1
    (req.rd && req.addr == PORT1_PIN_LEVELS) |=> rdata == $past(pin_level_bit[1], 3))
    else $error("pin seen without sync delay");
  cover property (req.rd && req.addr == PORT3_PIN_LEVELS);
  cover property (req.wr);
  cover property (calm ##0 req.rd);
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pin_level_pkg::*;
  logic                        core_clk;
  logic                        rst;
  logic                        nmi_pin;
  port_byte_t [PORT_COUNT-1:0] pins;
  reg_req_t                    req;
  port_byte_t                  rdata;
  int                          num_errors, tests_run, cyc;
  port_pin_input_readback dut_u (.core_clk(core_clk), .rst(rst), .pin_level_bit(pins),
    .nmi_pin(nmi_pin), .req(req), .rdata(rdata));
  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input port_byte_t seen, input port_byte_t exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH rdata exp %h seen %h", exp, seen);
    end
  endtask
  task automatic rd(input reg_addr_t a, input port_byte_t e);
    @(posedge core_clk) req <= '{a, 8'h5a, 1'b0, 1'b1};
    @(posedge core_clk) req.rd <= 1'b0;
    @(negedge core_clk) chk(rdata, e);
  endtask
  // porta shares port4's offset, so it reads back port4
  function automatic port_byte_t want(int i);
    want = (i == 6) ? pins[4] : pins[i];
    if (i == 3) want[5] = nmi_pin;
  endfunction
  task automatic sweep(input int n);
    for (int i = 0; i < PORT_COUNT; i++) rd(PORT_OFFSET[i], want(i));
    $display("test %0d done", n);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      conclude;
    end
  end
  initial begin
    {rst, nmi_pin, req, cyc, num_errors, tests_run} = '0;
    rst = 1'b1;
    for (int i = 0; i < PORT_COUNT; i++) pins[i] = {4'(i), 4'(15 - i)};
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    sweep(1);
    @(posedge core_clk) req <= '{PORT0_PIN_LEVELS, ~pins[0], 1'b1, 1'b0};
    @(posedge core_clk) req.wr <= 1'b0;
    rd(PORT0_PIN_LEVELS, want(0));
    rd(20'h8c046, 8'h00);
    $display("test 2 done");
    // old level must still show while the synchroniser fills
    @(posedge core_clk);
    pins <= ~pins;
    nmi_pin <= 1'b1;
    rd(PORT1_PIN_LEVELS, want(1));
    repeat (6) @(posedge core_clk);
    sweep(3);
    conclude;
  end
endmodule
bind port_pin_input_readback pin_level_monitor mon_u (.core_clk(core_clk), .rst(rst),
  .pin_level_bit(pin_level_bit), .nmi_pin(nmi_pin), .req(req), .rdata(rdata));
`default_nettype wire
